/* eil_pkg.sv */
/*
 * package of the external interrupt latch: register map, field positions, reset values
 * assumes: included before every other file of the block
 */
package eil_pkg;
	localparam logic [15:0] EIL_STATUS_CONTROL_ADDR = 16'h001a;
	localparam int EIL_LEVEL_SENSE_BIT = 0;
	localparam int EIL_REQUEST_MASK_BIT = 1;
	localparam int EIL_ACK_BIT = 2;
	localparam int EIL_PENDING_BIT = 3;
	localparam logic [7:0] EIL_STATUS_CONTROL_RESET = 8'h00;
	localparam logic [15:0] EIL_IRQ_STATUS_ADDR = 16'h001b;
	localparam logic [15:0] EIL_IRQ_MASK_ADDR = 16'h001c;
	localparam int EIL_EVT_LATCH_BIT = 0;
	localparam int EIL_EVT_ACK_BIT = 1;
	localparam int EIL_EVT_WIDTH = 2;
	localparam logic [7:0] EIL_IRQ_STATUS_RESET = 8'h00;
	localparam logic [7:0] EIL_IRQ_MASK_RESET = 8'h00;
	localparam logic [15:0] EIL_VECTOR_HI_ADDR = 16'hfffa;
	localparam logic [15:0] EIL_VECTOR_LO_ADDR = 16'hfffb;
	typedef enum logic [1:0] {EIL_IDLE, EIL_LATCHED, EIL_WAIT_HIGH} eil_state_e;
endpackage

/* eil_pin_if.sv */
/*
 * interface carrying the synchronised pin view between the synchroniser and the latch
 * assumes: one clock domain
 */
`timescale 1ns/1ps
`default_nettype none
interface eil_pin_if;
	logic pin_level;
	logic fall_pulse;
	modport src (output pin_level, output fall_pulse);
	modport dst (input pin_level, input fall_pulse);
endinterface
`default_nettype wire

/* eil_pin_sync.sv */
/*
 * synchroniser and falling-edge detector for the active-low interrupt pin
 * assumes: pin is asynchronous to clk; rst synchronous active high
 */
`timescale 1ns/1ps
`default_nettype none
module eil_pin_sync
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// raw pin, active low
	input wire logic irq_pin_n,
	// synchronised view
	eil_pin_if.src pin
);
	logic meta;
	logic sync;
	logic prev;

	// first stage read only by second stage; no reset here, so a pin
	// held low through reset is not taken for a fresh edge afterwards
	always_ff @(posedge clk)
	begin
		meta <= irq_pin_n;
		sync <= meta;
	end

	// edge memory cleared in reset: the first sample after it never counts as a fall
	always_ff @(posedge clk)
	begin
		if (rst)
			prev <= 1'b0;
		else
			prev <= sync;
	end

	assign pin.pin_level = sync;
	assign pin.fall_pulse = prev & ~sync;
endmodule // eil_pin_sync
`default_nettype wire

/* external_interrupt_latch.sv */
/*
 * external interrupt latch: pin latch, acknowledge, mask, pending flag and status register
 * assumes: synchronous register port with read data one cycle after the read strobe;
 * break state and clear-enable come from the system integration unit; the cpu
 * global mask comes from the condition code register
 */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_latch
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// external pin, active low
	input wire logic irq_pin_n,
	// cpu side
	input wire logic vector_fetch_ack,
	input wire logic cpu_global_mask,
	output logic cpu_irq_req,
	output logic [15:0] vector_addr_hi,
	output logic [15:0] vector_addr_lo,
	// break control
	input wire logic break_state,
	input wire logic break_clear_enable,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// interrupt output
	output logic irq
);
	import eil_pkg::*;

	eil_pin_if pin_bus();

	eil_pin_sync u_sync
	(
		.clk(clk),
		.rst(rst),
		.irq_pin_n(irq_pin_n),
		.pin(pin_bus.src)
	);

	eil_state_e state;
	eil_state_e next_state;
	logic level_sense_select;
	logic request_mask;
	logic [EIL_EVT_WIDTH-1:0] irq_status;
	logic [EIL_EVT_WIDTH-1:0] irq_mask;
	logic [EIL_EVT_WIDTH-1:0] next_irq_status;

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	wire sel_sc = reg_addr == EIL_STATUS_CONTROL_ADDR;
	wire sel_st = reg_addr == EIL_IRQ_STATUS_ADDR;
	wire sel_mk = reg_addr == EIL_IRQ_MASK_ADDR;
	wire wr_sc = reg_wr & sel_sc;
	wire wr_st = reg_wr & sel_st;
	wire wr_mk = reg_wr & sel_mk;
	// ack write ignored in break unless clear-enable
	wire sw_ack = wr_sc & reg_wdata[EIL_ACK_BIT] & (~break_state | break_clear_enable);
	wire any_ack = sw_ack | vector_fetch_ack;
	wire pin_low = ~pin_bus.dst.pin_level;
	wire fall = pin_bus.dst.fall_pulse;
	wire pending = state != EIL_IDLE;
	wire next_level_sense = wr_sc ? reg_wdata[EIL_LEVEL_SENSE_BIT] : level_sense_select;

	// ------------------------------------------------------------
	// latch state machine
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			EIL_IDLE:
				if (fall)
					next_state = EIL_LATCHED;
			EIL_LATCHED:
				if (any_ack)
				begin
					if (fall)
						next_state = EIL_LATCHED;
					else if (level_sense_select & pin_low)
						next_state = EIL_WAIT_HIGH;
					else
						next_state = EIL_IDLE;
				end
			EIL_WAIT_HIGH:
				// ack already seen; only the pin or a mode change releases it
				if (fall)
					next_state = EIL_LATCHED;
				else if (~pin_low | ~level_sense_select)
					next_state = EIL_IDLE;
			default:
				next_state = EIL_IDLE;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= EIL_IDLE;
		else
			state <= next_state;
	end

	// ------------------------------------------------------------
	// control bits
	// ------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			level_sense_select <= EIL_STATUS_CONTROL_RESET[EIL_LEVEL_SENSE_BIT];
			request_mask <= EIL_STATUS_CONTROL_RESET[EIL_REQUEST_MASK_BIT];
		end
		else if (wr_sc)
		begin
			level_sense_select <= next_level_sense;
			request_mask <= reg_wdata[EIL_REQUEST_MASK_BIT];
		end
	end

	// ------------------------------------------------------------
	// event status, set wins over write-one clear
	// ------------------------------------------------------------
	wire [EIL_EVT_WIDTH-1:0] evt_set = {any_ack & pending, fall};
	wire [EIL_EVT_WIDTH-1:0] evt_clr = wr_st ? reg_wdata[EIL_EVT_WIDTH-1:0] : '0;
	assign next_irq_status = (irq_status & ~evt_clr) | evt_set;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irq_status <= EIL_IRQ_STATUS_RESET[EIL_EVT_WIDTH-1:0];
			irq_mask <= EIL_IRQ_MASK_RESET[EIL_EVT_WIDTH-1:0];
		end
		else
		begin
			irq_status <= next_irq_status;
			if (wr_mk)
				irq_mask <= reg_wdata[EIL_EVT_WIDTH-1:0];
		end
	end

	// ------------------------------------------------------------
	// outputs and read data
	// ------------------------------------------------------------
	wire next_pending = next_state != EIL_IDLE;
	wire next_req = next_pending & ~request_mask & ~cpu_global_mask;
	// pending shows the state before a write in the same cycle lands
	wire [7:0] sc_read = {4'h0, pending, 1'b0, request_mask, level_sense_select};
	wire [7:0] rd_mux = sel_sc ? sc_read :
		sel_st ? {6'h00, irq_status} :
		sel_mk ? {6'h00, irq_mask} : 8'h00;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cpu_irq_req <= 1'b0;
			irq <= 1'b0;
			reg_rdata <= 8'h00;
			vector_addr_hi <= EIL_VECTOR_HI_ADDR;
			vector_addr_lo <= EIL_VECTOR_LO_ADDR;
		end
		else
		begin
			cpu_irq_req <= next_req;
			irq <= |(next_irq_status & irq_mask);
			reg_rdata <= reg_rd ? rd_mux : 8'h00;
			vector_addr_hi <= EIL_VECTOR_HI_ADDR;
			vector_addr_lo <= EIL_VECTOR_LO_ADDR;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_fall_edge;
		pin_bus.dst.fall_pulse;
	endsequence

	sequence s_sw_ack;
		sw_ack;
	endsequence

	sequence s_latched_ack;
		state == EIL_LATCHED && any_ack && !fall;
	endsequence

	sequence s_level_low;
		level_sense_select && pin_low;
	endsequence

	sequence s_break_clear;
		break_state && break_clear_enable && sw_ack && state == EIL_LATCHED && !level_sense_select && !fall;
	endsequence

	property p_fall_sets;
		@(posedge clk) disable iff (rst) s_fall_edge |=> pending;
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall did not latch");

	property p_edge_ack_clears;
		@(posedge clk) disable iff (rst)
			(state == EIL_LATCHED && any_ack && !level_sense_select && !fall) |=> !pending;
	endproperty
	a_edge_ack_clears: assert property (p_edge_ack_clears) else $error("edge ack failed");

	property p_vec_ack_clears;
		@(posedge clk) disable iff (rst)
			(state == EIL_LATCHED && vector_fetch_ack && !fall && !(level_sense_select && pin_low)) |=> !pending;
	endproperty
	a_vec_ack_clears: assert property (p_vec_ack_clears) else $error("vector ack failed");

	property p_level_holds;
		@(posedge clk) disable iff (rst)
			(pending && level_sense_select && pin_low && !wr_sc) |=> pending;
	endproperty
	a_level_holds: assert property (p_level_holds) else $error("level dropped latch");

	property p_break_protect;
		@(posedge clk) disable iff (rst)
			(state == EIL_LATCHED && break_state && !break_clear_enable && !vector_fetch_ack) |=> pending;
	endproperty
	a_break_protect: assert property (p_break_protect) else $error("break ack cleared");

	property p_mask_blocks;
		@(posedge clk) disable iff (rst) request_mask |=> !cpu_irq_req;
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("mask leaked");

	property p_global_blocks;
		@(posedge clk) disable iff (rst) cpu_global_mask |=> !cpu_irq_req;
	endproperty
	a_global_blocks: assert property (p_global_blocks) else $error("global mask leaked");

	property p_ack_reads_zero;
		@(posedge clk) disable iff (rst) 1'b1 |-> reg_rdata[EIL_ACK_BIT] == 1'b0 && reg_rdata[7:4] == 4'h0;
	endproperty
	a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack read nonzero");

	property p_pending_read;
		@(posedge clk) disable iff (rst) (reg_rd && sel_sc) |=> reg_rdata[EIL_PENDING_BIT] == $past(pending);
	endproperty
	a_pending_read: assert property (p_pending_read) else $error("pending flag wrong");

	property p_reset_clears;
		@(posedge clk) rst |=> !pending && !level_sense_select;
	endproperty
	a_reset_clears: assert property (p_reset_clears) else $error("reset left latch");

	// ------------------------------------------------------------
	// assertions: acknowledge paths, level wait, break and outputs
	// ------------------------------------------------------------
	property p_sw_ack_clears;
		@(posedge clk) disable iff (rst)
			s_sw_ack ##0 (state == EIL_LATCHED && !level_sense_select && !fall) |=> !pending;
	endproperty
	a_sw_ack_clears: assert property (p_sw_ack_clears) else $error("software ack did not clear");

	property p_level_ack_waits;
		@(posedge clk) disable iff (rst)
			s_latched_ack ##0 s_level_low |=> state == EIL_WAIT_HIGH;
	endproperty
	a_level_ack_waits: assert property (p_level_ack_waits) else $error("level ack did not wait");

	property p_wait_high_clears;
		@(posedge clk) disable iff (rst)
			(state == EIL_WAIT_HIGH && !pin_low) |=> !pending;
	endproperty
	a_wait_high_clears: assert property (p_wait_high_clears) else $error("pin high did not clear");

	property p_wait_holds;
		@(posedge clk) disable iff (rst)
			(state == EIL_WAIT_HIGH) ##0 s_level_low |=> pending;
	endproperty
	a_wait_holds: assert property (p_wait_holds) else $error("wait dropped with pin low");

	property p_idle_quiet;
		@(posedge clk) disable iff (rst)
			(state == EIL_IDLE && !fall) |=> !pending;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("latch set without edge");

	property p_req_follows;
		@(posedge clk) disable iff (rst)
			(next_pending && !request_mask && !cpu_global_mask) |=> cpu_irq_req;
	endproperty
	a_req_follows: assert property (p_req_follows) else $error("unmasked request missing");

	property p_poll_ignores_mask;
		@(posedge clk) disable iff (rst)
			(reg_rd && sel_sc && pending && request_mask) |=> reg_rdata[EIL_PENDING_BIT];
	endproperty
	a_poll_ignores_mask: assert property (p_poll_ignores_mask) else $error("pending hidden by mask");

	property p_break_no_sw;
		@(posedge clk) disable iff (rst)
			(wr_sc && reg_wdata[EIL_ACK_BIT] && break_state && !break_clear_enable) |-> !sw_ack;
	endproperty
	a_break_no_sw: assert property (p_break_no_sw) else $error("ack passed in break");

	property p_break_clear_stays;
		@(posedge clk) disable iff (rst)
			s_break_clear ##1 !fall |=> !pending;
	endproperty
	a_break_clear_stays: assert property (p_break_clear_stays) else $error("break clear did not stay");

	property p_vector_fixed;
		@(posedge clk) disable iff (rst)
			1'b1 |-> vector_addr_hi == EIL_VECTOR_HI_ADDR && vector_addr_lo == EIL_VECTOR_LO_ADDR;
	endproperty
	a_vector_fixed: assert property (p_vector_fixed) else $error("vector address wrong");

	property p_reset_quiet;
		@(posedge clk)
			rst |=> !cpu_irq_req && !irq && reg_rdata == 8'h00;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs live in reset");
endmodule // external_interrupt_latch
`default_nettype wire

/* eil_cpu_model.sv */
/* cpu and pin source model beside the external interrupt latch
 assumes: clk shared with the bench, rst synchronous active high */
`timescale 1ns/1ps
`default_nettype none
module eil_cpu_model
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// block side
	input wire logic cpu_irq_req,
	output logic vector_fetch_ack,
	output logic irq_pin_n,
	// behaviour control
	input wire logic ack_en,
	input wire logic [3:0] ack_delay
);
	logic [3:0] wait_cnt;
	initial irq_pin_n = 1'b1;
	task automatic drive_pin(input logic v);
		@(posedge clk);
		irq_pin_n <= v;
	endtask
	// one fetch per request while ack_delay is below 4'hf; the counter saturates so a held request is not refetched
	always_ff @(posedge clk)
	begin
		if (rst || !ack_en || !cpu_irq_req)
		begin
			wait_cnt <= 4'h0;
			vector_fetch_ack <= 1'b0;
		end
		else
		begin
			vector_fetch_ack <= (wait_cnt == ack_delay);
			if (wait_cnt != 4'hf)
				wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // eil_cpu_model
`default_nettype wire

/* external_interrupt_latch_bench.sv */
/* self-checking bench of the external interrupt latch
 assumes: eil_pkg, eil_pin_if and the design compiled first */
`timescale 1ns/1ps
`default_nettype none
module external_interrupt_latch_bench;
	logic clk = 1'b0, rst = 1'b1, cpu_global_mask = 1'b0;
	logic break_state = 1'b0, break_clear_enable = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, ack_en = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic [3:0] ack_delay = 4'h0;
	logic vector_fetch_ack, cpu_irq_req, irq, irq_pin_n;
	logic [15:0] vector_addr_hi, vector_addr_lo;
	logic [7:0] reg_rdata;
	int miscompares = 0, checks = 0, cycles = 0;
	always #10 clk = ~clk;
	external_interrupt_latch u_external_interrupt_latch (.clk(clk), .rst(rst), .irq_pin_n(irq_pin_n),
		.vector_fetch_ack(vector_fetch_ack), .cpu_global_mask(cpu_global_mask), .cpu_irq_req(cpu_irq_req),
		.vector_addr_hi(vector_addr_hi), .vector_addr_lo(vector_addr_lo), .break_state(break_state),
		.break_clear_enable(break_clear_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	eil_cpu_model u_eil_cpu_model (.clk(clk), .rst(rst), .cpu_irq_req(cpu_irq_req),
		.vector_fetch_ack(vector_fetch_ack), .irq_pin_n(irq_pin_n), .ack_en(ack_en), .ack_delay(ack_delay));
	// ----------------
	// shared tasks
	// ----------------
	task automatic final_report;
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk({8'h00, reg_rdata}, {8'h00, exp});
	endtask
	// sync plus latch take three edges; six leaves margin
	task automatic pin(input logic v);
		u_eil_cpu_model.drive_pin(v);
		repeat (6) @(posedge clk);
		#1;
	endtask
	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset;
		rd(16'h001a, 8'h00);
		rd(16'h001b, 8'h00);
		rd(16'h001c, 8'h00);
		rd(16'h0030, 8'h00);
		chk(vector_addr_hi, 16'hfffa);
		chk(vector_addr_lo, 16'hfffb);
	endtask
	task automatic t_edge;
		pin(1'b0);
		chk(cpu_irq_req, 1'b1);
		rd(16'h001a, 8'h08);
		wr(16'h001a, 8'h04);
		rd(16'h001a, 8'h00);
		pin(1'b1);
		pin(1'b0);
		rd(16'h001a, 8'h08);
		wr(16'h001a, 8'h04);
		pin(1'b1);
	endtask
	task automatic t_mask;
		wr(16'h001a, 8'h02);
		pin(1'b0);
		chk(cpu_irq_req, 1'b0);
		rd(16'h001a, 8'h0a);
		wr(16'h001a, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk(cpu_irq_req, 1'b1);
		@(posedge clk) cpu_global_mask <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(cpu_irq_req, 1'b0);
		@(posedge clk) cpu_global_mask <= 1'b0;
		wr(16'h001a, 8'h04);
		pin(1'b1);
	endtask
	task automatic t_level;
		wr(16'h001a, 8'h01);
		pin(1'b0);
		wr(16'h001a, 8'h05);
		rd(16'h001a, 8'h09);
		pin(1'b1);
		rd(16'h001a, 8'h01);
		pin(1'b0);
		pin(1'b1);
		rd(16'h001a, 8'h09);
		wr(16'h001a, 8'h05);
		rd(16'h001a, 8'h01);
		wr(16'h001a, 8'h00);
	endtask
	logic [3:0] ack_delay_set [2] = '{4'h0, 4'h9};
	// prompt and slow vector fetch
	task automatic t_vector;
		foreach (ack_delay_set[i])
		begin
			@(posedge clk);
			ack_en <= 1'b1;
			ack_delay <= ack_delay_set[i];
			pin(1'b0);
			repeat (16) @(posedge clk);
			rd(16'h001a, 8'h00);
			chk(cpu_irq_req, 1'b0);
			pin(1'b1);
		end
		@(posedge clk) ack_en <= 1'b0;
	endtask
	task automatic t_break;
		@(posedge clk) break_state <= 1'b1;
		pin(1'b0);
		wr(16'h001a, 8'h04);
		rd(16'h001a, 8'h08);
		@(posedge clk) break_clear_enable <= 1'b1;
		wr(16'h001a, 8'h04);
		rd(16'h001a, 8'h00);
		@(posedge clk) break_state <= 1'b0;
		rd(16'h001a, 8'h00);
		@(posedge clk) break_clear_enable <= 1'b0;
		pin(1'b1);
	endtask
	task automatic t_event;
		wr(16'h001b, 8'h03);
		wr(16'h001c, 8'h01);
		pin(1'b0);
		chk(irq, 1'b1);
		wr(16'h001c, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk(irq, 1'b0);
		wr(16'h001a, 8'h04);
		rd(16'h001b, 8'h03);
		wr(16'h001b, 8'h03);
		rd(16'h001b, 8'h00);
		pin(1'b1);
	endtask
	task automatic t_reset_low;
		wr(16'h001a, 8'h03);
		pin(1'b0);
		@(posedge clk) rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(16'h001a, 8'h00);
		// pin still low: nothing may re-latch, as the unreset synchroniser kept the low level through reset
		repeat (6) @(posedge clk);
		rd(16'h001a, 8'h00);
		chk(cpu_irq_req, 1'b0);
		pin(1'b1);
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			final_report;
		end
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_edge;
		t_mask;
		t_level;
		t_vector;
		t_break;
		t_event;
		t_reset_low;
		final_report;
	end
endmodule // external_interrupt_latch_bench
`default_nettype wire
